// ===== include/snz_pkg.sv
// ----------------------------------------------------------------------
// Shared constants and types of the serial snooze controller
// ----------------------------------------------------------------------
package snz_pkg;

    // ------------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;                    // Byte address width
    localparam int DATA_W = 32;                   // Register data width
    localparam int CHAR_W = 8;                    // Received character width

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00; // snooze_control_reg
    localparam logic [ADDR_W-1:0] OFS_RELSEL = 5'h04; // snooze_release_select_reg
    localparam logic [ADDR_W-1:0] OFS_IEN    = 5'h08; // interrupt_enable_reg
    localparam logic [ADDR_W-1:0] OFS_CMP    = 5'h0c; // compare_data_reg
    localparam logic [ADDR_W-1:0] OFS_STAT   = 5'h10; // Sticky event status
    localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h14; // Event interrupt mask
    localparam logic [ADDR_W-1:0] OFS_MODE   = 5'h18; // Current operating mode

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_SEL_LSB   = 0;            // serial_snooze_select[1:0]
    localparam int CTRL_XFER_BIT  = 2;            // snooze_transfer_enable
    localparam int CTRL_MATCH_BIT = 3;            // Data match detection enable
    localparam int CTRL_RXEN_BIT  = 4;            // Serial reception enable
    localparam int REL_ERE_BIT    = 0;            // rx_error_release_select
    localparam int REL_RXE_LSB    = 1;            // rx_full_release_select[1:0]
    localparam int IEN_SNZ_BIT    = 0;            // snooze_irq_enable

    // Status bits, shared by the mask register
    localparam int STAT_W        = 6;
    localparam int ST_RELEASE    = 0;             // Snooze release interrupt pending
    localparam int ST_ENTER      = 1;             // Entered snooze
    localparam int ST_MISMATCH   = 2;             // Returned to standby on mismatch
    localparam int ST_XFER_END   = 3;             // Returned to standby after transfer
    localparam int ST_RXFULL     = 4;             // Receive data full pending
    localparam int ST_RXERR      = 5;             // Receive error pending

    // ------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_COMPARE = 2'h2;    // Mismatch returns to standby
    localparam logic [1:0] SEL_XFER    = 2'h3;    // Also return after transfer
    localparam logic [1:0] RXE_FULL    = 2'h1;    // Receive full is the source

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SNOOZE  = 2'b10,
        MODE_XFER    = 2'b11
    } snz_mode_t;

    // ------------------------------------------------------------------
    // Register port request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                  // Byte address
        logic [DATA_W-1:0] wdata;                 // Write data
        logic              wr;                    // Write strobe
        logic              rd;                    // Read strobe
    } snz_bus_t;

    // ------------------------------------------------------------------
    // Whole state of the controller
    // ------------------------------------------------------------------
    typedef struct packed {
        snz_mode_t         mode;                  // Operating mode
        logic [2:0]        sync;                  // Pin synchroniser chain
        logic              pin_lvl;               // Filtered pin level
        logic [1:0]        sel;                   // serial_snooze_select
        logic              xfer_en;               // snooze_transfer_enable
        logic              match_en;              // Match detection enable
        logic              rx_en;                 // Reception enable
        logic              ere;                   // rx_error_release_select
        logic [1:0]        rxe;                   // rx_full_release_select
        logic              ien;                   // snooze_irq_enable
        logic [CHAR_W-1:0] cmp;                   // Compare character
        logic [STAT_W-1:0] stat;                  // Sticky events
        logic [STAT_W-1:0] mask;                  // Event mask
        logic [DATA_W-1:0] rdata;                 // Read answer
        logic              irq;                   // Event interrupt
        logic              snz_irq;               // Release interrupt request
        logic              xfer_req;              // Transfer start pulse
    } snz_state_t;

    // Reset value: line idle high, everything else cleared
    localparam snz_state_t STATE_RST = '{
        mode: MODE_NORMAL, sync: 3'h7, pin_lvl: 1'h1, sel: 2'h0,
        xfer_en: 1'h0, match_en: 1'h0, rx_en: 1'h0, ere: 1'h0, rxe: 2'h0,
        ien: 1'h0, cmp: 8'h00, stat: 6'h00, mask: 6'h00, rdata: 32'h0,
        irq: 1'h0, snz_irq: 1'h0, xfer_req: 1'h0};

endpackage

// ===== rtl/snz_ctrl.sv
// Function
// - Wait with reception enabled enters armed standby
// - Standby falling edge on pin enters snooze
// - Compare received character with compare data
// - Compare mode mismatch returns to standby
// - Match raises release interrupt, back to normal
// - Full or transfer release shows release and receive-full pending
// - Error select zero: error never releases
// - Full select 01 makes receive-full the source
// - Release request reaches processor only when enabled
// - Transfer mode: after transfer, back to standby
// - Last transfer raises release, back to normal
// - Select 11 returns to standby after transfer
// - Transfer enable lets transfers run in snooze
// - Full select 1x makes transfer-end the source
// - Error select one makes receive error release
`timescale 1ns/10ps

module snz_ctrl (
    input  wire logic                        i_mclk,      // 100 MHz clock
    input  wire logic                        i_rst,       // Async reset, high
    input  wire logic                        i_ce,        // Clock enable
    input  wire snz_pkg::snz_bus_t           i_bus,       // Register request
    output logic [snz_pkg::DATA_W-1:0]       o_rdata,     // Read answer
    input  wire logic                        i_wait,      // Wait instruction pulse
    input  wire logic                        i_rx_pin,    // serial_receive_pin
    input  wire logic                        i_rx_full,   // Character received
    input  wire logic                        i_rx_error,  // Receive error
    input  wire logic [snz_pkg::CHAR_W-1:0]  i_rx_data,   // Received character
    input  wire logic                        i_xfer_done, // Transfer finished
    input  wire logic                        i_xfer_last, // That one was the last
    output logic [1:0]                       o_mode,      // Operating mode
    output logic                             o_xfer_req,  // Start one transfer
    output logic                             o_snz_irq,   // snooze_release_irq
    output logic                             o_rx_full_irq, // Receive full pending
    output logic                             o_rx_err_irq,  // Receive error pending
    output logic                             o_irq        // Masked event interrupt
);

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    snz_pkg::snz_state_t st;                      // Registered state
    snz_pkg::snz_state_t next_st;                 // Next state

    // Decoded events, visible to the checks below
    logic fall;                                   // Filtered falling edge
    logic match;                                  // Character equals compare
    logic rd_stat;                                // Status read, clears it

    // ------------------------------------------------------------------
    // Register decode helper
    // ------------------------------------------------------------------
    // True when a strobe addresses the given offset
    function automatic logic hit(input logic strobe,
                                 input logic [snz_pkg::ADDR_W-1:0] a,
                                 input logic [snz_pkg::ADDR_W-1:0] ofs);
        hit = strobe && (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [snz_pkg::STAT_W-1:0] set_vec;      // Events of this cycle
        set_vec = '0;
        next_st = st;
        next_st.xfer_req = 1'b0;

        // Pin filter: the second and third stage must agree
        next_st.sync = {st.sync[1:0], i_rx_pin};
        if (st.sync[1] == st.sync[2]) begin
            next_st.pin_lvl = st.sync[2];
        end
        fall = st.pin_lvl && !st.sync[1] && !st.sync[2];

        // Match only counts when detection is on; off means no match
        match = st.match_en && (i_rx_data == st.cmp);
        rd_stat = hit(i_bus.rd, i_bus.addr, snz_pkg::OFS_STAT);

        // Mode sequencing
        case (st.mode)
            snz_pkg::MODE_NORMAL: begin
                // Stays here until software waits again
                if (i_wait && st.rx_en) begin
                    next_st.mode = snz_pkg::MODE_STANDBY;
                end
            end
            snz_pkg::MODE_STANDBY: begin
                // Start bit edge wakes the receiver
                if (fall) begin
                    next_st.mode = snz_pkg::MODE_SNOOZE;
                    set_vec[snz_pkg::ST_ENTER] = 1'b1;
                end
            end
            snz_pkg::MODE_SNOOZE: begin
                if (i_rx_error) begin
                    // Error wakes only when selected
                    if (st.ere) begin
                        next_st.mode = snz_pkg::MODE_NORMAL;
                        set_vec[snz_pkg::ST_RELEASE] = 1'b1;
                        set_vec[snz_pkg::ST_RXERR] = 1'b1;
                    end else begin
                        next_st.mode = snz_pkg::MODE_STANDBY;
                    end
                end else if (i_rx_full) begin
                    if ((st.sel == snz_pkg::SEL_COMPARE ||
                         st.sel == snz_pkg::SEL_XFER) && !match) begin
                        // Wrong character: sleep again quietly
                        next_st.mode = snz_pkg::MODE_STANDBY;
                        set_vec[snz_pkg::ST_MISMATCH] = 1'b1;
                    end else if (st.sel == snz_pkg::SEL_XFER && st.xfer_en) begin
                        // Hand the character to the transfer controller
                        next_st.mode = snz_pkg::MODE_XFER;
                        next_st.xfer_req = 1'b1;
                    end else if (st.rxe == snz_pkg::RXE_FULL) begin
                        next_st.mode = snz_pkg::MODE_NORMAL;
                        set_vec[snz_pkg::ST_RELEASE] = 1'b1;
                        set_vec[snz_pkg::ST_RXFULL] = 1'b1;
                    end else begin
                        // No source selected: nothing can release
                        next_st.mode = snz_pkg::MODE_STANDBY;
                    end
                end
            end
            snz_pkg::MODE_XFER: begin
                if (i_xfer_done) begin
                    if (i_xfer_last && st.rxe[1]) begin
                        next_st.mode = snz_pkg::MODE_NORMAL;
                        set_vec[snz_pkg::ST_RELEASE] = 1'b1;
                        set_vec[snz_pkg::ST_RXFULL] = 1'b1;
                    end else begin
                        next_st.mode = snz_pkg::MODE_STANDBY;
                        set_vec[snz_pkg::ST_XFER_END] = 1'b1;
                    end
                end
            end
            default: begin
                next_st.mode = snz_pkg::MODE_NORMAL;
            end
        endcase

        // Register writes
        if (hit(i_bus.wr, i_bus.addr, snz_pkg::OFS_CTRL)) begin
            next_st.sel      = i_bus.wdata[snz_pkg::CTRL_SEL_LSB +: 2];
            next_st.xfer_en  = i_bus.wdata[snz_pkg::CTRL_XFER_BIT];
            next_st.match_en = i_bus.wdata[snz_pkg::CTRL_MATCH_BIT];
            next_st.rx_en    = i_bus.wdata[snz_pkg::CTRL_RXEN_BIT];
        end
        if (hit(i_bus.wr, i_bus.addr, snz_pkg::OFS_RELSEL)) begin
            next_st.ere = i_bus.wdata[snz_pkg::REL_ERE_BIT];
            next_st.rxe = i_bus.wdata[snz_pkg::REL_RXE_LSB +: 2];
        end
        if (hit(i_bus.wr, i_bus.addr, snz_pkg::OFS_IEN)) begin
            next_st.ien = i_bus.wdata[snz_pkg::IEN_SNZ_BIT];
        end
        if (hit(i_bus.wr, i_bus.addr, snz_pkg::OFS_CMP)) begin
            next_st.cmp = i_bus.wdata[snz_pkg::CHAR_W-1:0];
        end
        if (hit(i_bus.wr, i_bus.addr, snz_pkg::OFS_MASK)) begin
            next_st.mask = i_bus.wdata[snz_pkg::STAT_W-1:0];
        end

        // Read clears status, but a new event in the same cycle survives
        next_st.stat = (rd_stat ? '0 : st.stat) | set_vec;

        // Read answer, present only in the cycle after the strobe
        next_st.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                snz_pkg::OFS_CTRL: begin
                    next_st.rdata[snz_pkg::CTRL_SEL_LSB +: 2]  = st.sel;
                    next_st.rdata[snz_pkg::CTRL_XFER_BIT]      = st.xfer_en;
                    next_st.rdata[snz_pkg::CTRL_MATCH_BIT]     = st.match_en;
                    next_st.rdata[snz_pkg::CTRL_RXEN_BIT]      = st.rx_en;
                end
                snz_pkg::OFS_RELSEL: begin
                    next_st.rdata[snz_pkg::REL_ERE_BIT]        = st.ere;
                    next_st.rdata[snz_pkg::REL_RXE_LSB +: 2]   = st.rxe;
                end
                snz_pkg::OFS_IEN: begin
                    next_st.rdata[snz_pkg::IEN_SNZ_BIT]        = st.ien;
                end
                snz_pkg::OFS_CMP: begin
                    next_st.rdata[snz_pkg::CHAR_W-1:0]         = st.cmp;
                end
                snz_pkg::OFS_STAT: begin
                    next_st.rdata[snz_pkg::STAT_W-1:0]         = st.stat;
                end
                snz_pkg::OFS_MASK: begin
                    next_st.rdata[snz_pkg::STAT_W-1:0]         = st.mask;
                end
                snz_pkg::OFS_MODE: begin
                    next_st.rdata[1:0]                         = st.mode;
                end
                default: begin
                    // Unmapped offsets read as zero
                    next_st.rdata = '0;
                end
            endcase
        end

        // Interrupt outputs are registered from the next status
        next_st.irq     = |(next_st.stat & next_st.mask);
        next_st.snz_irq = next_st.stat[snz_pkg::ST_RELEASE] && next_st.ien;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Clock enable low freezes everything, synchroniser included
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st <= snz_pkg::STATE_RST;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign o_rdata       = st.rdata;
    assign o_mode        = st.mode;
    assign o_xfer_req    = st.xfer_req;
    assign o_snz_irq     = st.snz_irq;
    assign o_rx_full_irq = st.stat[snz_pkg::ST_RXFULL];
    assign o_rx_err_irq  = st.stat[snz_pkg::ST_RXERR];
    assign o_irq         = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Snooze with an active character arriving
    sequence s_char_in;
        st.mode == snz_pkg::MODE_SNOOZE && i_ce && i_rx_full && !i_rx_error;
    endsequence

    // Compare mode with a wrong character
    sequence s_mismatch;
        s_char_in ##0 (st.sel == snz_pkg::SEL_COMPARE) && !match;
    endsequence

    // A release from snooze: back in normal with the request raised
    sequence s_released;
        st.mode == snz_pkg::MODE_NORMAL && st.stat[snz_pkg::ST_RELEASE];
    endsequence

    property p_wait_standby;
        st.mode == snz_pkg::MODE_NORMAL && i_ce && i_wait && st.rx_en
            |=> st.mode == snz_pkg::MODE_STANDBY;
    endproperty
    a_wait_standby: assert property (p_wait_standby)
        else $error("wait did not enter standby");

    property p_edge_snooze;
        st.mode == snz_pkg::MODE_STANDBY && i_ce && fall
            |=> st.mode == snz_pkg::MODE_SNOOZE && st.stat[snz_pkg::ST_ENTER];
    endproperty
    a_edge_snooze: assert property (p_edge_snooze)
        else $error("falling edge did not enter snooze");

    property p_mismatch;
        s_mismatch |=> st.mode == snz_pkg::MODE_STANDBY && !st.stat[snz_pkg::ST_RELEASE];
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatch did not return to standby");

    property p_match_release;
        s_char_in ##0 (st.sel == snz_pkg::SEL_COMPARE) && match
            && st.rxe == snz_pkg::RXE_FULL |=> s_released;
    endproperty
    a_match_release: assert property (p_match_release)
        else $error("match did not release snooze");

    property p_both_pending;
        $rose(st.mode == snz_pkg::MODE_NORMAL) && st.stat[snz_pkg::ST_RELEASE]
            && !st.stat[snz_pkg::ST_RXERR]
            |-> o_rx_full_irq && (o_snz_irq == st.ien);
    endproperty
    a_both_pending: assert property (p_both_pending)
        else $error("release without pending receive full");

    property p_err_ignored;
        st.mode == snz_pkg::MODE_SNOOZE && i_ce && i_rx_error && !st.ere
            |=> st.mode == snz_pkg::MODE_STANDBY;
    endproperty
    a_err_ignored: assert property (p_err_ignored)
        else $error("unselected error released snooze");

    property p_err_release;
        st.mode == snz_pkg::MODE_SNOOZE && i_ce && i_rx_error && st.ere
            |=> s_released ##0 o_rx_err_irq;
    endproperty
    a_err_release: assert property (p_err_release)
        else $error("selected error did not release");

    property p_irq_gate;
        o_snz_irq |-> st.ien && st.stat[snz_pkg::ST_RELEASE];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("release request without enable");

    property p_xfer_entry;
        $rose(st.mode == snz_pkg::MODE_XFER) |-> o_xfer_req && $past(st.xfer_en);
    endproperty
    a_xfer_entry: assert property (p_xfer_entry)
        else $error("transfer entered without enable");

    property p_xfer_back;
        st.mode == snz_pkg::MODE_XFER && i_ce && i_xfer_done && !i_xfer_last
            |=> st.mode == snz_pkg::MODE_STANDBY && st.stat[snz_pkg::ST_XFER_END];
    endproperty
    a_xfer_back: assert property (p_xfer_back)
        else $error("transfer end did not return to standby");

    property p_xfer_last;
        st.mode == snz_pkg::MODE_XFER && i_ce && i_xfer_done && i_xfer_last && st.rxe[1]
            |=> s_released;
    endproperty
    a_xfer_last: assert property (p_xfer_last)
        else $error("last transfer did not release");

    property p_normal_hold;
        st.mode == snz_pkg::MODE_NORMAL && !(i_ce && i_wait)
            |=> st.mode == snz_pkg::MODE_NORMAL;
    endproperty
    a_normal_hold: assert property (p_normal_hold)
        else $error("left normal mode without wait");

endmodule // snz_ctrl

// ===== sim/snz_tx_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Far-end transmitter: low frame on the line, then a finished character
// ----------------------------------------------------------------------
module snz_tx_model (
    input  wire logic       i_mclk,  // System clock
    input  wire logic       i_go,    // Send one character
    input  wire logic [7:0] i_data,  // Character to send
    output logic            o_pin,   // Line level, idle high
    output logic            o_full,  // Character complete pulse
    output logic [7:0]      o_data   // Received character
);
    logic [3:0] cnt    = 4'h0;       // Frame time left
    logic       full_q = 1'b0;       // Character complete pulse
    logic [7:0] dat_q  = 8'h00;      // Character beside the pulse
    // Data is only meaningful beside the full pulse, so it toggles otherwise
    always @(posedge i_mclk) begin
        full_q <= (cnt == 4'h1);
        dat_q  <= (cnt == 4'h1) ? i_data : ~dat_q;
        if (i_go) cnt <= 4'hc;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    assign o_pin = (cnt < 4'h3);     // Start bit gives the falling edge
    assign o_full = full_q;
    assign o_data = dat_q;
endmodule // snz_tx_model

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic i_mclk = 0, i_rst = 1, i_wait = 0, xd = 0, xl = 0, go = 0, es = 0;
    logic [7:0] ch = 8'h00, rxd;
    snz_pkg::snz_bus_t bus = '0;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic xreq, sirq, fi, ei, irq, pin, full;
    int err_total = 0, tests_run = 0, cyc = 0;
    logic [31:0] nreq = 32'h0;  // Transfer start pulses seen
    always #5 i_mclk = ~i_mclk;
    // Count one-cycle transfer requests so none is missed between checks
    always @(posedge i_mclk) begin
        if (xreq === 1'b1) nreq <= nreq + 32'h1;
    end
    snz_tx_model tx (.i_mclk(i_mclk), .i_go(go), .i_data(ch), .o_pin(pin), .o_full(full),
        .o_data(rxd));
    snz_ctrl uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
        .i_wait(i_wait), .i_rx_pin(pin), .i_rx_full(full), .i_rx_error(full & es),
        .i_rx_data(rxd), .i_xfer_done(xd), .i_xfer_last(xl), .o_mode(mode),
        .o_xfer_req(xreq), .o_snz_irq(sirq), .o_rx_full_irq(fi), .o_rx_err_irq(ei), .o_irq(irq));
    task automatic final_report();
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        @(posedge i_mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk) bus <= '0;
    endtask
    task automatic rd(logic [4:0] a, logic [31:0] e);
        @(posedge i_mclk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk) bus <= '0;
        #1 chk("rdata", e, rdata);
    endtask
    task automatic sleep(); // Wait instruction, then expect standby
        @(posedge i_mclk) i_wait <= 1'b1;
        @(posedge i_mclk) i_wait <= 1'b0;
        #1 chk("mode", 32'h1, {30'h0, mode});
    endtask
    task automatic send(logic [7:0] c, logic e);
        @(posedge i_mclk) go <= 1'b1;
        ch <= c;
        es <= e;
        @(posedge i_mclk) go <= 1'b0;
        repeat (16) @(posedge i_mclk);
        #1;
    endtask
    task automatic pulse_done(logic last);
        @(posedge i_mclk) xd <= 1'b1;
        xl <= last;
        @(posedge i_mclk) xd <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1 chk("mode", 32'h0, {30'h0, mode});
        rd(snz_pkg::OFS_STAT, 32'h0);
        rd(5'h1c, 32'h0);
        wr(snz_pkg::OFS_CTRL, 32'h1a);
        wr(snz_pkg::OFS_RELSEL, 32'h2);
        wr(snz_pkg::OFS_IEN, 32'h1);
        wr(snz_pkg::OFS_CMP, 32'h5a);
        wr(snz_pkg::OFS_MASK, 32'h3f);
        rd(snz_pkg::OFS_CTRL, 32'h1a);
        sleep();
        rd(snz_pkg::OFS_MODE, 32'h1);
        send(8'ha5, 1'b0);
        chk("mode", 32'h1, {30'h0, mode});
        rd(snz_pkg::OFS_STAT, 32'h6);
        send(8'h5a, 1'b0);
        chk("mode", 32'h0, {30'h0, mode});
        chk("irqs", 32'h7, {29'h0, sirq, fi, irq});
        rd(snz_pkg::OFS_STAT, 32'h13);
        send(8'h5a, 1'b0);
        chk("mode", 32'h0, {30'h0, mode});
        wr(snz_pkg::OFS_IEN, 32'h0);
        sleep();
        send(8'h5a, 1'b0);
        chk("irqs", 32'h1, {30'h0, sirq, fi});
        wr(snz_pkg::OFS_RELSEL, 32'h3);
        sleep();
        send(8'h5a, 1'b1);
        chk("err", 32'h1, {29'h0, mode, ei});
        wr(snz_pkg::OFS_RELSEL, 32'h2);
        sleep();
        send(8'h5a, 1'b1);
        chk("mode", 32'h1, {30'h0, mode});
        wr(snz_pkg::OFS_CTRL, 32'h1f);
        wr(snz_pkg::OFS_RELSEL, 32'h4);
        wr(snz_pkg::OFS_IEN, 32'h1);
        send(8'h5a, 1'b0);
        chk("mode", 32'h3, {30'h0, mode});
        pulse_done(1'b0);
        chk("mode", 32'h1, {30'h0, mode});
        send(8'ha5, 1'b0);
        chk("mode", 32'h1, {30'h0, mode});
        send(8'h5a, 1'b0);
        pulse_done(1'b1);
        chk("rel", 32'h1, {29'h0, mode, sirq});
        chk("xreq", 32'h2, nreq);
        final_report();
    end
endmodule // tb_top
